/* reset_strap_boot_config.sv */
// Boot strap capture, boot sequencing and derived pin configuration
//
// Summary of operation
// - Sample data bus bits 6..0 only during hardware reset
// - Strap bit 0 high runs program shadow copy
// - Bit 4 high enables serial programming, holds CPU
// - Bit 4 low releases CPU, no serial programming
// - Bit 5 high selects 921.6 kbps programming baud
// - Bit 5 low selects 115.2 kbps programming baud
// - Baud strap ignored when programming strapped off
// - Bit 6 high skips EEPROM, low loads it
// - EEPROM byte 1 size field sets SRAM window
// - EEPROM debug select routes three debugger pins
// - Two external interrupts: low level or falling edge
// - Interrupt 0 also serves as wakeup input
// - Flash strobes and SRAM selects are active low
//
`timescale 1ns/1ps
`default_nettype none
`include "boot_strap_defines.svh"
module reset_strap_boot_config
  import boot_strap_pkg::*;
#(
  parameter int STRAP_BITS = `STRAP_WIDTH,
  parameter int ADDR_BITS = 21
) (
  // Clock and hardware reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Strap pins sampled during reset
  input wire logic [7:0] ext_mem_data_bus,
  // EEPROM loader handshake
  input wire logic eeprom_byte_valid,
  input wire logic [7:0] eeprom_byte_offset,
  input wire logic [7:0] eeprom_byte_data,
  input wire logic eeprom_load_done,
  // Shadow copier handshake and program serial port done
  input wire logic shadow_copy_done,
  input wire logic serial_program_done,
  // SRAM address decode request and memory strobe requests
  input wire logic [ADDR_BITS-1:0] sram_addr,
  input wire logic sram_access,
  input wire logic flash_read_req,
  input wire logic flash_write_req,
  // Debugger and network status sources
  input wire logic debugger_clock_src,
  input wire logic debugger_data_src,
  input wire logic link_led_src,
  input wire logic speed_led_src,
  input wire logic duplex_led_src,
  input wire logic debugger_data_in,
  // External interrupt pins and per-pin edge mode
  input wire logic [1:0] ext_int_n,
  input wire logic [1:0] int_edge_mode,
  // Captured strap view
  output logic program_shadow_strap,
  output logic [1:0] local_bus_clock_mode_strap,
  output logic serial_flash_program_strap,
  output logic fast_program_baud_strap,
  output logic eeprom_config_skip_strap,
  // Boot control
  output logic eeprom_load_start,
  output logic shadow_copy_start,
  output logic cpu_reset_hold,
  output logic serial_program_enable,
  output logic [15:0] program_baud_divisor,
  // Memory enables, active low
  output logic sram_chip_select0_n,
  output logic flash_read_strobe_n,
  output logic flash_write_strobe_n,
  // SRAM size and debug pin routing
  output logic [2:0] sram_size_select,
  output logic debug_pin_select,
  output logic debugger_clock_out,
  output logic debugger_data_out,
  output logic link_led_in_use,
  // Interrupts and wakeup
  output logic [1:0] ext_int_req,
  output logic wakeup_input
);

  initial begin
    if (STRAP_BITS != `STRAP_WIDTH || ADDR_BITS < 20) begin
      $error("reset_strap_boot_config: unsupported parameters");
    end
  end

  logic [6:0] strap_r;
  logic [7:0] cfg_byte1_r;
  boot_state_t state_r;
  boot_state_t state_nxt;
  logic [1:0] int_prev_r;

  // Address limit for chip select 0 from the size field
  function automatic logic in_sram_window(input logic [2:0] sel,
                                          input logic [ADDR_BITS-1:0] a);
    logic ok;
    ok = 1'b0;
    unique case (sel)
      SIZE_64K: ok = (a[ADDR_BITS-1:16] == '0);
      SIZE_128K: ok = (a[ADDR_BITS-1:17] == '0);
      SIZE_256K: ok = (a[ADDR_BITS-1:18] == '0);
      SIZE_512K: ok = (a[ADDR_BITS-1:19] == '0);
      SIZE_1024K: ok = (a[ADDR_BITS-1:20] == '0);
      default: ok = (a[ADDR_BITS-1:16] == '0);
    endcase
    return ok;
  endfunction

  // Sample the pins every cycle of hardware reset, freeze afterwards;
  // a software reset never reaches this block so cannot resample
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      strap_r <= ext_mem_data_bus[6:0];
    end
  end

  // Config byte 1 is taken from the EEPROM only while loading
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfg_byte1_r <= `CFG_BYTE1_RESET;
    end else if (state_r == ST_EEPROM && eeprom_byte_valid &&
                 eeprom_byte_offset == `CFG_BYTE1_OFFSET) begin
      cfg_byte1_r <= eeprom_byte_data;
    end
  end

  // Boot sequence: optional EEPROM load, optional shadow copy, run
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: begin
        if (!strap_r[`STRAP_EEPROM_SKIP_BIT]) begin
          state_nxt = ST_EEPROM;
        end else if (strap_r[`STRAP_SHADOW_BIT]) begin
          state_nxt = ST_SHADOW;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      ST_EEPROM: begin
        if (eeprom_load_done) begin
          state_nxt = strap_r[`STRAP_SHADOW_BIT] ? ST_SHADOW : ST_RUN;
        end
      end
      ST_SHADOW: begin
        if (shadow_copy_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Strap view outputs, registered from the frozen copy
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      program_shadow_strap <= 1'b0;
      local_bus_clock_mode_strap <= 2'b00;
      serial_flash_program_strap <= 1'b0;
      fast_program_baud_strap <= 1'b0;
      eeprom_config_skip_strap <= 1'b0;
    end else begin
      program_shadow_strap <= strap_r[`STRAP_SHADOW_BIT];
      // Board must pull mode high and sync low; reported as strapped
      local_bus_clock_mode_strap <= {strap_r[`STRAP_LB_SYNC_BIT],
                                     strap_r[`STRAP_LB_MODE_BIT]};
      serial_flash_program_strap <= strap_r[`STRAP_PROGRAM_BIT];
      // Baud strap only meaningful with programming on
      fast_program_baud_strap <= strap_r[`STRAP_PROGRAM_BIT] &
                                 strap_r[`STRAP_FAST_BAUD_BIT];
      eeprom_config_skip_strap <= strap_r[`STRAP_EEPROM_SKIP_BIT];
    end
  end

  // Boot control strobes and CPU hold
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      eeprom_load_start <= 1'b0;
      shadow_copy_start <= 1'b0;
      cpu_reset_hold <= 1'b1;
      serial_program_enable <= 1'b0;
    end else begin
      eeprom_load_start <= (state_r == ST_RESET) && (state_nxt == ST_EEPROM);
      shadow_copy_start <= (state_r != ST_SHADOW) && (state_nxt == ST_SHADOW);
      serial_program_enable <= strap_r[`STRAP_PROGRAM_BIT];
      // CPU held while loading or copying, and while programming is strapped
      // on, except in each cycle that follows one where serial_program_done is high
      cpu_reset_hold <= (state_nxt != ST_RUN) ||
                        (strap_r[`STRAP_PROGRAM_BIT] && !serial_program_done);
    end
  end

  // Programming baud divisor; zero while programming is off
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      program_baud_divisor <= 16'h0000;
    end else if (!strap_r[`STRAP_PROGRAM_BIT]) begin
      program_baud_divisor <= 16'h0000;
    end else if (strap_r[`STRAP_FAST_BAUD_BIT]) begin
      program_baud_divisor <= 16'(`BAUD_FAST_DIV);
    end else begin
      program_baud_divisor <= 16'(`BAUD_NORMAL_DIV);
    end
  end

  // Active-low memory enables; idle high
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sram_chip_select0_n <= 1'b1;
      flash_read_strobe_n <= 1'b1;
      flash_write_strobe_n <= 1'b1;
      sram_size_select <= 3'b000;
    end else begin
      sram_size_select <= cfg_byte1_r[`CFG_SIZE_MSB:`CFG_SIZE_LSB];
      sram_chip_select0_n <= !(sram_access &&
        in_sram_window(cfg_byte1_r[`CFG_SIZE_MSB:`CFG_SIZE_LSB], sram_addr));
      flash_read_strobe_n <= !flash_read_req;
      flash_write_strobe_n <= !flash_write_req;
    end
  end

  // Debug pins: debugger or network status indicators
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      debug_pin_select <= 1'b0;
      debugger_clock_out <= 1'b0;
      debugger_data_out <= 1'b0;
      link_led_in_use <= 1'b0;
    end else begin
      debug_pin_select <= cfg_byte1_r[`CFG_DEBUG_SEL_BIT];
      if (cfg_byte1_r[`CFG_DEBUG_SEL_BIT]) begin
        debugger_clock_out <= speed_led_src;
        debugger_data_out <= duplex_led_src;
        link_led_in_use <= link_led_src;
      end else begin
        debugger_clock_out <= debugger_clock_src;
        debugger_data_out <= debugger_data_src;
        link_led_in_use <= 1'b0;
      end
    end
  end

  // Interrupts: low level, or falling edge when the mode bit is set
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      int_prev_r <= 2'b11;
      ext_int_req <= 2'b00;
      wakeup_input <= 1'b0;
    end else begin
      int_prev_r <= ext_int_n;
      for (int i = 0; i < 2; i++) begin
        ext_int_req[i] <= int_edge_mode[i] ? (int_prev_r[i] & ~ext_int_n[i])
                                           : ~ext_int_n[i];
      end
      wakeup_input <= ~ext_int_n[0];
    end
  end

endmodule
`default_nettype wire

/* boot_strap_defines.svh */
// Strap bit positions, configuration field layout and timing constants
`ifndef BOOT_STRAP_DEFINES_SVH
`define BOOT_STRAP_DEFINES_SVH
`define STRAP_WIDTH 7
`define STRAP_SHADOW_BIT 0
`define STRAP_LB_MODE_BIT 1
`define STRAP_LB_SYNC_BIT 2
`define STRAP_PROGRAM_BIT 4
`define STRAP_FAST_BAUD_BIT 5
`define STRAP_EEPROM_SKIP_BIT 6
`define CFG_BYTE1_OFFSET 8'h01
`define CFG_SIZE_LSB 0
`define CFG_SIZE_MSB 2
`define CFG_DEBUG_SEL_BIT 3
`define CFG_BYTE1_RESET 8'h00
`define BAUD_FAST_BPS 921600
`define BAUD_NORMAL_BPS 115200
`define CLK_HZ 20000000
`define BAUD_FAST_DIV ((`CLK_HZ) / (`BAUD_FAST_BPS))
`define BAUD_NORMAL_DIV ((`CLK_HZ) / (`BAUD_NORMAL_BPS))
`endif

/* boot_strap_pkg.sv */
// Types for the boot strap configuration loader
package boot_strap_pkg;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_EEPROM = 2'b01,
    ST_SHADOW = 2'b10,
    ST_RUN = 2'b11
  } boot_state_t;
  typedef enum logic [2:0] {
    SIZE_64K = 3'b000,
    SIZE_128K = 3'b001,
    SIZE_256K = 3'b010,
    SIZE_512K = 3'b011,
    SIZE_1024K = 3'b100
  } sram_size_t;
endpackage

/* reset_strap_boot_config_properties.sv */
// Port-level assertions for the boot strap configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "boot_strap_defines.svh"
module boot_config_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Watched inputs
  input wire logic flash_read_req,
  input wire logic flash_write_req,
  input wire logic serial_program_done,
  input wire logic [1:0] ext_int_n,
  input wire logic [1:0] int_edge_mode,
  // Watched outputs
  input wire logic flash_read_strobe_n,
  input wire logic flash_write_strobe_n,
  input wire logic sram_chip_select0_n,
  input wire logic cpu_reset_hold,
  input wire logic wakeup_input,
  input wire logic [1:0] ext_int_req,
  input wire logic program_shadow_strap,
  input wire logic [1:0] local_bus_clock_mode_strap,
  input wire logic serial_flash_program_strap,
  input wire logic fast_program_baud_strap,
  input wire logic eeprom_config_skip_strap,
  input wire logic serial_program_enable,
  input wire logic [15:0] program_baud_divisor
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] up_r;
  logic settled;
  // Reset history: captured straps need a few edges to land after release
  always_ff @(posedge core_clk) up_r <= {up_r[1:0], reset_n};
  assign settled = reset_n && (up_r == 3'h7);
  read_strobe_a: assert property ($past(reset_n) |-> flash_read_strobe_n == !$past(flash_read_req))
    else $error("flash read strobe wrong");
  write_strobe_a: assert property ($past(reset_n) |-> flash_write_strobe_n == !$past(flash_write_req))
    else $error("flash write strobe wrong");
  reset_hold_a: assert property (!$past(reset_n) |-> cpu_reset_hold && sram_chip_select0_n)
    else $error("cpu not held or select active after reset");
  wake_follow_a: assert property ($past(reset_n) |-> wakeup_input == !$past(ext_int_n[0]))
    else $error("wakeup does not follow interrupt pin 0");
  int_level_a: assert property ($past(reset_n) && !$past(int_edge_mode[0])
    |-> ext_int_req[0] == !$past(ext_int_n[0]))
    else $error("level interrupt wrong");
  int_low_a: assert property ($past(reset_n) && ext_int_req[1] |-> !$past(ext_int_n[1]))
    else $error("interrupt 1 raised with pin high");
  strap_hold_a: assert property (settled |-> $stable({program_shadow_strap, local_bus_clock_mode_strap,
    serial_flash_program_strap, fast_program_baud_strap, eeprom_config_skip_strap}))
    else $error("strap view changed after reset");
  baud_ignore_a: assert property (!serial_flash_program_strap |-> !fast_program_baud_strap)
    else $error("fast baud without programming");
  baud_div_a: assert property (settled |-> program_baud_divisor == (!serial_flash_program_strap ? 16'h0
    : fast_program_baud_strap ? 16'(`BAUD_FAST_DIV) : 16'(`BAUD_NORMAL_DIV)))
    else $error("baud divisor wrong");
  prog_enable_a: assert property (settled |-> serial_program_enable == serial_flash_program_strap)
    else $error("programming enable wrong");
  hold_release_a: assert property ($fell(cpu_reset_hold)
    |-> !serial_flash_program_strap || $past(serial_program_done))
    else $error("cpu released during programming");
endmodule
bind reset_strap_boot_config boot_config_checker chk (.*);
`default_nettype wire

/* test_reset_strap_boot_config.sv */
// Self-checking bench for the boot strap configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "boot_strap_defines.svh"
module test_reset_strap_boot_config;
  logic core_clk = 0, reset_n = 0, eeprom_byte_valid = 0, eeprom_load_done = 0;
  logic shadow_copy_done = 0, serial_program_done = 0, sram_access = 0, debugger_data_in = 0;
  logic flash_read_req = 0, flash_write_req = 0, debugger_clock_src = 0, debugger_data_src = 0;
  logic link_led_src = 0, speed_led_src = 0, duplex_led_src = 0;
  logic [7:0] ext_mem_data_bus = 0, eeprom_byte_offset = 0, eeprom_byte_data = 0, cfg = 0;
  logic [20:0] sram_addr = 0;
  logic [1:0] ext_int_n = 2'h3, int_edge_mode = 0, ext_int_req, local_bus_clock_mode_strap;
  logic program_shadow_strap, serial_flash_program_strap, fast_program_baud_strap;
  logic eeprom_config_skip_strap, eeprom_load_start, shadow_copy_start, cpu_reset_hold;
  logic serial_program_enable, sram_chip_select0_n, flash_read_strobe_n, flash_write_strobe_n;
  logic debug_pin_select, debugger_clock_out, debugger_data_out, link_led_in_use, wakeup_input;
  logic [2:0] sram_size_select;
  logic [15:0] program_baud_divisor;
  logic [31:0] rv, rd;
  logic [4:0] prv;
  logic [6:0] tab [6] = '{7'h02, 7'h13, 7'h33, 7'h23, 7'h01, 7'h62};
  integer seed = 68702, err_count = 0, n_tests = 0, i;
  reset_strap_boot_config dut (.*);
  always #25 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Random traffic on pins the boot sequence does not steer; prv keeps what the dut sampled
  always @(posedge core_clk) begin
    rd = $random(seed);
    {ext_int_n, int_edge_mode, speed_led_src, duplex_led_src} <= rd[5:0];
    {debugger_clock_src, debugger_data_src, link_led_src} <= rd[8:6];
    {flash_read_req, flash_write_req} <= reset_n ? rd[10:9] : 2'h0;
    prv <= {link_led_src, speed_led_src, duplex_led_src, debugger_clock_src, debugger_data_src};
  end
  // Window probe: last byte inside selects, first byte past it does not
  task automatic mem_probe(input logic [20:0] lim);
    @(posedge core_clk);
    sram_access <= 1;
    sram_addr <= lim - 21'h1;
    @(posedge core_clk);
    sram_addr <= lim;
    @(negedge core_clk);
    chk(sram_chip_select0_n, 0);
    // Release on a rising edge; the dut still samples the held request there
    @(posedge core_clk);
    sram_access <= 0;
    @(negedge core_clk);
    chk(sram_chip_select0_n, 1);
  endtask
  // One hardware reset with straps s, then loader and copier stand-ins react to the dut
  task automatic boot(input logic [6:0] s, input logic [3:0] c);
    integer k, ee_t, sh_t, ee_n, sh_n;
    logic [2:0] sz;
    logic dbg;
    sz = s[6] ? 3'h0 : c[2:0];
    dbg = s[6] ? 1'b0 : c[3];
    cfg = {4'h0, c};
    ee_t = -20;
    sh_t = -20;
    ee_n = 0;
    sh_n = 0;
    @(posedge core_clk);
    reset_n <= 0;
    ext_mem_data_bus <= {1'b0, s};
    repeat (5) @(posedge core_clk);
    reset_n <= 1;
    ext_mem_data_bus <= {1'b1, ~s};
    for (k = 0; k < 60; k++) begin
      // Drive on the rising edge, read the registered pulses mid-cycle
      @(posedge core_clk);
      // Second byte arrives after the load ended and must be ignored
      eeprom_byte_valid <= (k == ee_t + 1) || (k == ee_t + 6) || (s[6] && k == 3);
      eeprom_byte_offset <= `CFG_BYTE1_OFFSET;
      eeprom_byte_data <= (k == ee_t + 1) ? cfg : 8'h0c;
      eeprom_load_done <= (k == ee_t + 4);
      shadow_copy_done <= (k == sh_t + 3);
      @(negedge core_clk);
      if (eeprom_load_start) ee_t = k;
      if (shadow_copy_start) sh_t = k;
      ee_n += eeprom_load_start;
      sh_n += shadow_copy_start;
    end
    chk(ee_n, !s[6]);
    chk(sh_n, s[0]);
    chk({program_shadow_strap, local_bus_clock_mode_strap, serial_flash_program_strap,
      fast_program_baud_strap, eeprom_config_skip_strap}, {s[0], s[2:1], s[4], s[4] & s[5], s[6]});
    chk(cpu_reset_hold, s[4]);
    chk(sram_size_select, sz);
    chk(debug_pin_select, dbg);
    chk({debugger_clock_out, debugger_data_out, link_led_in_use},
      dbg ? {prv[3:2], prv[4]} : {prv[1:0], 1'b0});
    mem_probe(21'h1 << (16 + sz));
    @(posedge core_clk);
    serial_program_done <= 1;
    repeat (4) @(posedge core_clk);
    serial_program_done <= 0;
    @(negedge core_clk);
    chk(cpu_reset_hold, 0);
  endtask
  // Hang guard sized well above the nine boots
  initial begin
    #100000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    for (i = 0; i < 9; i++) begin
      rv = $random(seed);
      boot(i < 6 ? tab[i] : rv[6:0], {i[0], 3'(i % 5)});
    end
    wrap_up;
  end
endmodule
`default_nettype wire
